// ### logic/coddc_pkg.sv
// Purpose: shared constants and types of the clock output divider and driver control
// Assumes: register word indices; byte address is four times the index
// Notes:   reset values and field positions of the four configuration registers
package coddc_pkg;

  // register word indices
  localparam logic [2:0] IDX_DIV_CFG = 3'h0;
  localparam logic [2:0] IDX_DRV_EN  = 3'h1;
  localparam logic [2:0] IDX_MODE    = 3'h2;
  localparam logic [2:0] IDX_AMP     = 3'h3;
  localparam logic [2:0] IDX_STATUS  = 3'h4;

  // reset values
  localparam logic [15:0] DIV_CFG_RST = 16'h8069;
  localparam logic [7:0]  DRV_EN_RST  = 8'h00;
  localparam logic [7:0]  MODE_RST    = 8'h6C;
  localparam logic [7:0]  AMP_RST     = 8'hB4;

  // writable bits; the rest read as zero
  localparam logic [15:0] DIV_CFG_WMASK = 16'hBFFF;
  localparam logic [15:0] DRV_EN_WMASK  = 16'h000F;
  localparam logic [15:0] BYTE_WMASK    = 16'h00FF;

  // divider ratio
  localparam int          RATIO_W   = 14;
  localparam logic [13:0] RATIO_MIN = 14'h000A;
  localparam logic [13:0] RATIO_RST = 14'h0069;

  // field positions
  localparam int DIV_REG_ON_BIT  = 15;
  localparam int DIS_STATE_LSB   = 2;
  localparam int FORCE_DIS_BIT   = 1;
  localparam int PD_BIT          = 0;
  localparam int CMOS_PH_LSB     = 6;
  localparam int LVDS_CM_LSB     = 4;
  localparam int HCSL_TERM_BIT   = 3;
  localparam int BIAS_BIT        = 2;
  localparam int TYPE_LSB        = 0;
  localparam int SWING_LSB       = 4;
  localparam int LVDS_AMP_BIT    = 3;

  // status word layout
  localparam int ST_ACTIVE_BIT   = 0;
  localparam int ST_POWERED_BIT  = 1;
  localparam int ST_DIV_RUN_BIT  = 2;
  localparam int ST_HELD_BIT     = 3;
  localparam int ST_CLAMP_BIT    = 4;
  localparam int ST_SWING_LSB    = 16;

  // hcsl swing in millivolts
  localparam logic [9:0] SWING_BASE_MV = 10'h0C8;
  localparam logic [9:0] SWING_STEP_MV = 10'h032;

  typedef enum logic [1:0] {
    TYPE_HCSL = 2'h0,
    TYPE_RSVD = 2'h1,
    TYPE_LVDS = 2'h2,
    TYPE_CMOS = 2'h3
  } coddc_type_t;

  typedef enum logic [1:0] {
    PH_SAME      = 2'h0,
    PH_OPPOSITE  = 2'h1,
    PH_TRUE_ONLY = 2'h2,
    PH_COMP_ONLY = 2'h3
  } coddc_phase_t;

  typedef enum logic [1:0] {
    DIS_LOW      = 2'h0,
    DIS_LOW_HIGH = 2'h1,
    DIS_HIZ      = 2'h2,
    DIS_RUN      = 2'h3
  } coddc_dis_t;

  function automatic logic [9:0] swing_mv(input logic [3:0] code);
    swing_mv = SWING_BASE_MV + ({6'h00, code} * SWING_STEP_MV);
  endfunction

endpackage

// ### logic/coddc_div_if.sv
// Purpose: link between the register block and the output divider
// Assumes: single clock domain
// Notes:   ratio is sampled by the divider only at a period boundary or while run is low
`timescale 1ns/1ps
interface coddc_div_if;
  logic [13:0] ratio;
  logic        run;
  logic        div_clk;

  modport ctl (output ratio, output run, input div_clk);
  modport div (input ratio, input run, output div_clk);
endinterface

// ### logic/coddc_divider.sv
// Purpose: output divider producing the divided clock level
// Assumes: source clock is clk_i
// Notes:   new ratio taken only at the rising boundary or while stopped, so no runt pulses
`timescale 1ns/1ps
module coddc_divider (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // divider link
  coddc_div_if.div  div_if
);

  typedef struct packed {
    logic [13:0] cnt;
    logic [13:0] ratio;
    logic        lvl;
  } coddc_div_st_t;

  localparam coddc_div_st_t DIV_ST_RST = '{cnt: 14'h0000, ratio: coddc_pkg::RATIO_RST,
                                           lvl: 1'b0};

  coddc_div_st_t st_reg;
  coddc_div_st_t st_next;
  logic [13:0]   eff_ratio;

  always_comb begin
    st_next   = st_reg;
    // ratios below the minimum are clamped rather than trusted
    eff_ratio = (div_if.ratio < coddc_pkg::RATIO_MIN) ? coddc_pkg::RATIO_MIN : div_if.ratio;
    if (!div_if.run) begin
      st_next.cnt   = 14'h0000;
      st_next.ratio = eff_ratio;
      st_next.lvl   = 1'b0;
    end else if (st_reg.cnt >= (st_reg.ratio - 14'h0001)) begin
      st_next.cnt   = 14'h0000;
      st_next.ratio = eff_ratio;
      st_next.lvl   = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 14'h0001;
      if (st_next.cnt == (st_reg.ratio >> 1)) begin
        st_next.lvl = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= DIV_ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign div_if.div_clk = st_reg.lvl;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_edge_at_boundary: assert property (
    $changed(st_reg.lvl) |-> (st_reg.cnt == 14'h0000) || (st_reg.cnt == (st_reg.ratio >> 1))
  ) else $error("divided clock edge away from a period boundary");

  a_ratio_at_wrap: assert property (
    $changed(st_reg.ratio) |-> (st_reg.cnt == 14'h0000)
  ) else $error("divider ratio changed inside a period");

  a_high_min_len: assert property (
    ($rose(st_reg.lvl) ##0 div_if.run [*5]) |-> st_reg.lvl
  ) else $error("divided clock high phase shorter than five cycles");

endmodule // coddc_divider

// ### logic/coddc_output_ctl.sv
// Purpose: register block and pin control of one clock output channel
// Assumes: Avalon-MM slave, word addressed, one cycle of waitrequest per access
// Notes:   pin states are registered, so they follow a register change one cycle later
// Function
// - bit 15 of divider config turns the divider regulator on; resets one
// - disabled-state field picks low/low, low/high, high-z or free running pins; low/low gives low/high on LVDS
// - forced-disable bit disables the driver; else other disable sources decide
// - power-down tri-states both pins and overrides every enable control
// - driver type field: 0 HCSL, 2 LVDS, 3 CMOS, 1 reserved; resets 0
// - CMOS phase field: same, opposite, true only, complement only; resets 1
// - LVDS common-mode field selects 700 to 1000 mV; resets to two
// - bit 3 enables internal 50-ohm HCSL termination; resets one
// - bit 2 of mode register enables driver bias; resets one
// - HCSL swing field, 200 mV plus 50 mV per code; resets 0xB
// - LVDS amplitude bit picks 350 or 400 mV; resets zero
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module coddc_output_ctl (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // avalon-mm slave
  input  wire logic [2:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // external output enable, high enables
  input  wire logic        output_enable_i,
  // analog controls
  output logic             divider_regulator_on_o,
  output logic             driver_power_down_o,
  output logic             driver_bias_on_o,
  output logic             hcsl_term_on_o,
  output logic      [1:0]  driver_type_o,
  output logic      [1:0]  lvds_common_mode_select_o,
  output logic      [3:0]  hcsl_swing_select_o,
  output logic             lvds_amplitude_select_o,
  // output pin pair
  output logic             clock_out_true_o,
  output logic             clock_out_true_oe_o,
  output logic             clock_out_complement_o,
  output logic             clock_out_complement_oe_o
);

  typedef struct packed {
    logic [15:0] div_cfg;
    logic [7:0]  drv_en;
    logic [7:0]  mode;
    logic [7:0]  amp;
    logic        ack;
    logic [31:0] rdata;
    logic        pin_t;
    logic        pin_c;
    logic        oe_t;
    logic        oe_c;
  } coddc_ctl_st_t;

  localparam coddc_ctl_st_t CTL_ST_RST = '{
    div_cfg: coddc_pkg::DIV_CFG_RST,
    drv_en:  coddc_pkg::DRV_EN_RST,
    mode:    coddc_pkg::MODE_RST,
    amp:     coddc_pkg::AMP_RST,
    ack:     1'b0,
    rdata:   32'h0000_0000,
    pin_t:   1'b0,
    pin_c:   1'b0,
    oe_t:    1'b0,
    oe_c:    1'b0
  };

  coddc_ctl_st_t         st_reg;
  coddc_ctl_st_t         st_next;
  coddc_div_if           div_if ();

  logic                  req;
  logic                  pd;
  logic                  disabled;
  logic                  drive;
  logic                  held;
  logic                  clamp;
  logic                  dclk;
  logic [15:0]           wd16;
  logic [15:0]           tmp16;
  coddc_pkg::coddc_type_t  dtype;
  coddc_pkg::coddc_phase_t phase;
  coddc_pkg::coddc_dis_t   dstate;

  // byte-lane merge of a write into a register of up to 16 bits
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [15:0] wd,
                                             input logic [15:0] wmask,
                                             input logic [1:0]  be);
    logic [15:0] m;
    m          = wmask & {{8{be[1]}}, {8{be[0]}}};
    lane_merge = (old & ~m) | (wd & m);
  endfunction

  coddc_divider u_divider (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .div_if    (div_if)
  );

  assign div_if.ratio = st_reg.div_cfg[13:0];
  assign div_if.run   = st_reg.div_cfg[coddc_pkg::DIV_REG_ON_BIT];
  assign dclk         = div_if.div_clk;

  always_comb begin
    st_next = st_reg;
    req     = avs_read_i | avs_write_i;
    wd16    = avs_writedata_i[15:0];
    tmp16   = 16'h0000;

    // pin state from the current configuration
    dtype    = coddc_pkg::coddc_type_t'(st_reg.mode[1:0]);
    phase    = coddc_pkg::coddc_phase_t'(st_reg.mode[7:6]);
    dstate   = coddc_pkg::coddc_dis_t'(st_reg.drv_en[3:2]);
    pd       = st_reg.drv_en[coddc_pkg::PD_BIT];
    // the external enable is the other disable source
    disabled = st_reg.drv_en[coddc_pkg::FORCE_DIS_BIT] | ~output_enable_i;
    drive    = ~pd & (~disabled | (dstate == coddc_pkg::DIS_RUN));
    held     = ~pd & ~drive;
    clamp    = (st_reg.div_cfg[13:0] < coddc_pkg::RATIO_MIN);

    if (pd) begin
      // power-down wins over every enable source
      st_next.pin_t = 1'b0;
      st_next.pin_c = 1'b0;
      st_next.oe_t  = 1'b0;
      st_next.oe_c  = 1'b0;
    end else if (drive) begin
      st_next.oe_t = 1'b1;
      st_next.oe_c = 1'b1;
      case (dtype)
        coddc_pkg::TYPE_CMOS: begin
          case (phase)
            coddc_pkg::PH_SAME: begin
              st_next.pin_t = dclk;
              st_next.pin_c = dclk;
            end
            coddc_pkg::PH_OPPOSITE: begin
              st_next.pin_t = dclk;
              st_next.pin_c = ~dclk;
            end
            coddc_pkg::PH_TRUE_ONLY: begin
              st_next.pin_t = dclk;
              st_next.pin_c = 1'b0;
            end
            default: begin
              st_next.pin_t = 1'b0;
              st_next.pin_c = dclk;
            end
          endcase
        end
        default: begin
          // hcsl, lvds and the reserved code all drive a differential pair
          st_next.pin_t = dclk;
          st_next.pin_c = ~dclk;
        end
      endcase
    end else begin
      case (dstate)
        coddc_pkg::DIS_LOW: begin
          st_next.oe_t  = 1'b1;
          st_next.oe_c  = 1'b1;
          st_next.pin_t = 1'b0;
          st_next.pin_c = (dtype == coddc_pkg::TYPE_LVDS);
        end
        coddc_pkg::DIS_LOW_HIGH: begin
          st_next.oe_t  = 1'b1;
          st_next.oe_c  = 1'b1;
          st_next.pin_t = 1'b0;
          st_next.pin_c = 1'b1;
        end
        default: begin
          st_next.oe_t  = 1'b0;
          st_next.oe_c  = 1'b0;
          st_next.pin_t = 1'b0;
          st_next.pin_c = 1'b0;
        end
      endcase
    end

    // bus handshake: one wait cycle, then the access completes
    st_next.ack = req & ~st_reg.ack;

    if (avs_read_i && !st_reg.ack) begin
      case (avs_address_i)
        coddc_pkg::IDX_DIV_CFG: st_next.rdata = {16'h0000, st_reg.div_cfg};
        coddc_pkg::IDX_DRV_EN:  st_next.rdata = {24'h000000, st_reg.drv_en};
        coddc_pkg::IDX_MODE:    st_next.rdata = {24'h000000, st_reg.mode};
        coddc_pkg::IDX_AMP:     st_next.rdata = {24'h000000, st_reg.amp};
        coddc_pkg::IDX_STATUS:  st_next.rdata = {6'h00, coddc_pkg::swing_mv(st_reg.amp[7:4]),
                                                 11'h000, clamp, held, div_if.run, ~pd, drive};
        default:                st_next.rdata = 32'h0000_0000;
      endcase
    end

    if (avs_write_i && st_reg.ack) begin
      case (avs_address_i)
        coddc_pkg::IDX_DIV_CFG: begin
          st_next.div_cfg = lane_merge(st_reg.div_cfg, wd16, coddc_pkg::DIV_CFG_WMASK,
                                       avs_byteenable_i[1:0]);
        end
        coddc_pkg::IDX_DRV_EN: begin
          tmp16          = lane_merge({8'h00, st_reg.drv_en}, wd16,
                                      coddc_pkg::DRV_EN_WMASK, avs_byteenable_i[1:0]);
          st_next.drv_en = tmp16[7:0];
        end
        coddc_pkg::IDX_MODE: begin
          tmp16        = lane_merge({8'h00, st_reg.mode}, wd16,
                                    coddc_pkg::BYTE_WMASK, avs_byteenable_i[1:0]);
          st_next.mode = tmp16[7:0];
        end
        coddc_pkg::IDX_AMP: begin
          tmp16       = lane_merge({8'h00, st_reg.amp}, wd16,
                                   coddc_pkg::BYTE_WMASK, avs_byteenable_i[1:0]);
          st_next.amp = tmp16[7:0];
        end
        default: begin
          // status and unmapped words ignore writes
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= CTL_ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_waitrequest_o         = req & ~st_reg.ack;
  assign avs_readdata_o            = st_reg.rdata;
  assign divider_regulator_on_o    = st_reg.div_cfg[coddc_pkg::DIV_REG_ON_BIT];
  assign driver_power_down_o       = st_reg.drv_en[coddc_pkg::PD_BIT];
  assign driver_bias_on_o          = st_reg.mode[coddc_pkg::BIAS_BIT];
  assign hcsl_term_on_o            = st_reg.mode[coddc_pkg::HCSL_TERM_BIT];
  assign driver_type_o             = st_reg.mode[1:0];
  assign lvds_common_mode_select_o = st_reg.mode[5:4];
  assign hcsl_swing_select_o       = st_reg.amp[7:4];
  assign lvds_amplitude_select_o   = st_reg.amp[coddc_pkg::LVDS_AMP_BIT];
  assign clock_out_true_o          = st_reg.pin_t;
  assign clock_out_true_oe_o       = st_reg.oe_t;
  assign clock_out_complement_o    = st_reg.pin_c;
  assign clock_out_complement_oe_o = st_reg.oe_c;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_regulator_write: assert property (
    (avs_write_i && st_reg.ack && avs_address_i == coddc_pkg::IDX_DIV_CFG
     && avs_byteenable_i[1])
    |=> divider_regulator_on_o == $past(avs_writedata_i[15]) && div_if.run == divider_regulator_on_o
  ) else $error("regulator enable does not follow the write");

  a_power_tristate: assert property (
    driver_power_down_o |=> !clock_out_true_oe_o && !clock_out_complement_oe_o
  ) else $error("pins driven while the driver is powered down");

  a_forced_hiz: assert property (
    (!driver_power_down_o && st_reg.drv_en[1] && st_reg.drv_en[3:2] == 2'h2)
    |=> !clock_out_true_oe_o && !clock_out_complement_oe_o
  ) else $error("forced disable with high-z state still drives pins");

  a_dis_low_low: assert property (
    (!pd && disabled && st_reg.drv_en[3:2] == 2'h0 && driver_type_o != 2'h2)
    |=> clock_out_true_oe_o && clock_out_complement_oe_o
        && !clock_out_true_o && !clock_out_complement_o
  ) else $error("disabled low/low state not held");

  a_dis_lvds_lh: assert property (
    (!pd && disabled && st_reg.drv_en[3:2] == 2'h0 && driver_type_o == 2'h2)
    |=> !clock_out_true_o && clock_out_complement_o
  ) else $error("disabled lvds state not held low/high");

  a_cmos_opposite: assert property (
    (drive && driver_type_o == 2'h3 && st_reg.mode[7:6] == 2'h1)
    |=> clock_out_complement_o == !clock_out_true_o
  ) else $error("cmos opposite phase broken");

  a_cmos_true_only: assert property (
    (drive && driver_type_o == 2'h3 && st_reg.mode[7:6] == 2'h2)
    |=> !clock_out_complement_o && clock_out_true_o == $past(dclk)
  ) else $error("cmos true-only phase broken");

  a_diff_pair: assert property (
    (drive && driver_type_o != 2'h3) |=> clock_out_complement_o != clock_out_true_o
  ) else $error("differential pair not complementary");

  a_mode_write: assert property (
    (avs_write_i && st_reg.ack && avs_address_i == coddc_pkg::IDX_MODE && avs_byteenable_i[0])
    |=> lvds_common_mode_select_o == $past(avs_writedata_i[5:4])
        && hcsl_term_on_o == $past(avs_writedata_i[3])
        && driver_bias_on_o == $past(avs_writedata_i[2])
        && driver_type_o == $past(avs_writedata_i[1:0])
  ) else $error("mode register write not applied");

  a_amp_write: assert property (
    (avs_write_i && st_reg.ack && avs_address_i == coddc_pkg::IDX_AMP && avs_byteenable_i[0])
    |=> hcsl_swing_select_o == $past(avs_writedata_i[7:4])
        && lvds_amplitude_select_o == $past(avs_writedata_i[3])
  ) else $error("amplitude register write not applied");

  a_bus_one_wait: assert property (
    (req && avs_waitrequest_o) |=> !avs_waitrequest_o
  ) else $error("waitrequest held longer than one cycle");

endmodule // coddc_output_ctl

// ### verif/coddc_rx_model.sv
// Purpose: downstream receiver watching the true pin of the output pair
// Assumes: sampled on the source clock, which is the divider source too
// Notes:   a released pin reads as its inverted last level, so hi-z never looks driven
`timescale 1ns/1ps
module coddc_rx_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // true pin
  input  wire logic true_i,
  input  wire logic true_oe_i,
  // measurements
  output int        rises_o,
  output int        period_o
);
  logic t_lvl;
  int   cnt;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      t_lvl    <= 1'b0;
      cnt      <= 0;
      rises_o  <= 0;
      period_o <= 0;
    end else begin
      t_lvl <= true_oe_i ? true_i : ~t_lvl;
      cnt   <= cnt + 1;
      // only a driven rise counts as a clock edge
      if (true_oe_i && true_i && !t_lvl) begin
        rises_o  <= rises_o + 1;
        period_o <= cnt + 1;
        cnt      <= 0;
      end
    end
  end
endmodule // coddc_rx_model

// ### verif/clock_output_divider_driver_ctl_test.sv
// Purpose: self-checking bench of the clock output channel control
// Assumes: avalon master waits for waitrequest low, no fixed latency
// Notes:   expected register and control-output values come from a shadow copy; pin values are fixed per case
`timescale 1ns/1ps
module clock_output_divider_driver_ctl_test;
  typedef struct {
    logic [2:0]  addr;
    logic [3:0]  be;
    logic [15:0] wd;
    logic [15:0] rd;
  } coddc_row_t;

  logic        clk_i     = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [2:0]  adr       = 3'h0;
  logic        rd_req    = 1'b0;
  logic        wr_req    = 1'b0;
  logic [3:0]  be        = 4'h0;
  logic [31:0] wdat      = 32'h0;
  logic        oe_in     = 1'b1;
  logic [31:0] rdat;
  logic        waitreq;
  logic        reg_on, pd, bias, term, lamp, t, toe, c, coe;
  logic [1:0]  dtype, cm;
  logic [3:0]  swing;
  logic [15:0] sh [4];
  logic [31:0] q;
  logic [1:0]  e;
  int          rises, period, n;
  int          miscompares = 0;
  int          num_checks  = 0;
  wire  [12:0] ctl  = {reg_on, pd, bias, term, dtype, cm, swing, lamp};
  wire  [3:0]  pins = {toe, coe, t, c};

  coddc_row_t rows [13] = '{
    '{3'h0, 4'hF, 16'hFFFF, 16'hBFFF}, '{3'h0, 4'hF, 16'h800A, 16'h800A},
    '{3'h0, 4'h2, 16'h0000, 16'h000A}, '{3'h0, 4'h1, 16'h80FF, 16'h00FF},
    '{3'h0, 4'hF, 16'h800A, 16'h800A}, '{3'h2, 4'hF, 16'h0000, 16'h0000},
    '{3'h2, 4'hF, 16'h00FF, 16'h00FF}, '{3'h2, 4'hF, 16'h006E, 16'h006E},
    '{3'h3, 4'hF, 16'h0008, 16'h0008}, '{3'h3, 4'hF, 16'h00F7, 16'h00F7},
    '{3'h1, 4'hF, 16'h00FF, 16'h000F}, '{3'h1, 4'hF, 16'h0000, 16'h0000},
    '{3'h5, 4'hF, 16'hFFFF, 16'h0000}
  };

  always #5 clk_i = ~clk_i;

  coddc_output_ctl DUT (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(adr), .avs_read_i(rd_req),
    .avs_write_i(wr_req), .avs_byteenable_i(be), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(waitreq), .output_enable_i(oe_in),
    .divider_regulator_on_o(reg_on), .driver_power_down_o(pd), .driver_bias_on_o(bias),
    .hcsl_term_on_o(term), .driver_type_o(dtype), .lvds_common_mode_select_o(cm),
    .hcsl_swing_select_o(swing), .lvds_amplitude_select_o(lamp),
    .clock_out_true_o(t), .clock_out_true_oe_o(toe), .clock_out_complement_o(c),
    .clock_out_complement_oe_o(coe)
  );

  coddc_rx_model rx (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .true_i(t), .true_oe_i(toe),
    .rises_o(rises), .period_o(period)
  );

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [2:0] a, input logic [3:0] b,
                     input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk_i);
    wr_req <= w;
    rd_req <= !w;
    adr    <= a;
    be     <= b;
    wdat   <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    if (k >= 50) miscompares++;
    r = rdat;
    wr_req <= 1'b0;
    rd_req <= 1'b0;
  endtask

  task automatic wreg(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, 4'hF, d, r);
  endtask

  task automatic rreg(input logic [2:0] a, output logic [31:0] r);
    bus(1'b0, a, 4'hF, 32'h0, r);
  endtask

  function automatic logic [12:0] ctl_exp();
    return {sh[0][15], sh[1][0], sh[2][2], sh[2][3], sh[2][1:0], sh[2][5:4],
            sh[3][7:4], sh[3][3]};
  endfunction

  task automatic chk_reset();
    logic [31:0] r;
    sh[0] = {1'b1, 1'b0, 14'h0069};
    sh[1] = 16'h0000;
    sh[2] = {8'h00, 2'h1, 2'h2, 1'b1, 1'b1, 2'h0};
    sh[3] = {8'h00, 4'hB, 1'b0, 3'h4};
    for (int i = 0; i < 4; i++) begin
      rreg(i[2:0], r);
      cmp("reset value", {16'h0, sh[i]}, r);
    end
    cmp("reset controls", 32'(ctl_exp()), 32'(ctl));
  endtask

  task automatic pins_is(input logic [3:0] exp, input string name);
    repeat (4) @(posedge clk_i);
    cmp(name, 32'(exp), 32'(pins));
  endtask

  // the third rise after the call is timed: a new ratio is only taken at the
  // next wrap, so the first period seen may still run at the old ratio
  task automatic period_is(input int exp);
    int s;
    s = rises;
    for (int k = 0; k < 3000 && rises < s + 3; k++) @(posedge clk_i);
    cmp("period", 32'(exp), 32'(period));
  endtask

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #500000;
    miscompares++;
    wrap_up();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    chk_reset();
    period_is(105);
    // upper data bits set to show they are ignored
    foreach (rows[i]) begin
      bus(1'b1, rows[i].addr, rows[i].be, {16'hFFFF, rows[i].wd}, q);
      rreg(rows[i].addr, q);
      cmp("readback", {16'h0, rows[i].rd}, q);
      if (rows[i].addr < 3'h4) sh[rows[i].addr] = rows[i].rd;
      cmp("controls", 32'(ctl_exp()), 32'(ctl));
    end
    rreg(3'h4, q);
    cmp("status swing", 32'(200 + 50 * 15), {22'h0, q[25:16]});
    cmp("status flags", 32'h07, {27'h0, q[4:0]});
    period_is(10);
    for (int ty = 0; ty < 3; ty += 2) begin
      wreg(3'h2, {24'h0, 2'h1, 2'h2, 2'h3, ty[1:0]});
      for (int st = 0; st < 3; st++) begin
        wreg(3'h1, {28'h0, st[1:0], 2'h2});
        pins_is(st == 2 ? 4'h0 : {2'h3, 1'b0, (st == 1 || ty == 2)}, "dis pins");
      end
    end
    wreg(3'h1, 32'h0000000E);
    n = rises;
    // the divided clock phase is free here, so only the pair relation is fixed
    repeat (4) @(posedge clk_i);
    cmp("debug drive", 32'h7, {29'h0, toe, coe, t ^ c});
    repeat (40) @(posedge clk_i);
    cmp("debug run", 32'h1, {31'h0, rises > n + 2});
    cmp("debug oe", 32'h3, {30'h0, toe, coe});
    wreg(3'h1, 32'h00000004);
    @(posedge clk_i);
    oe_in <= 1'b0;
    pins_is(4'hD, "ext disable");
    wreg(3'h1, 32'h0000000D);
    pins_is(4'h0, "power down");
    @(posedge clk_i);
    oe_in <= 1'b1;
    pins_is(4'h0, "power down en");
    wreg(3'h1, 32'h00000000);
    wreg(3'h0, 32'h0000000A);
    pins_is(4'hD, "regulator off");
    wreg(3'h0, 32'h00008014);
    period_is(20);
    wreg(3'h0, 32'h0000800C);
    period_is(12);
    for (int ph = 0; ph < 4; ph++) begin
      wreg(3'h2, {24'h0, ph[1:0], 4'hF, 2'h3});
      repeat (3) @(posedge clk_i);
      n = 0;
      repeat (20) begin
        @(posedge clk_i);
        n += int'(t) + int'(c);
        e = ph == 0 ? {t, t} : ph == 1 ? {t, ~t} : ph == 2 ? {t, 1'b0} : {1'b0, c};
        cmp("cmos pair", {28'h0, 2'h3, e}, 32'(pins));
      end
      cmp("cmos toggles", 32'h1, {31'h0, n > 0});
    end
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    cmp("reset pins", 32'h0, 32'(pins));
    reset_n_i <= 1'b1;
    chk_reset();
    wrap_up();
  end
endmodule // clock_output_divider_driver_ctl_test
